/* File: verif/analog_far_model.sv */
// far side model: analog input level and counter overflow source
`timescale 1ns/1ps
module analog_far_model (
    // clock and controls
    input  wire logic       clk,
    input  wire logic       trig_en,
    input  wire logic [9:0] level,
    // converter side
    input  wire logic [9:0] dac_code,
    output wire logic       comparator_in,
    output wire logic       hw_conv_trigger
);
    logic [8:0] cnt_q = '0;
    // comparator keeps the trial bit while the input reaches it
    assign comparator_in = level >= dac_code;
    // overflow every 300 cycles, pulse wide enough to synchronise
    always_ff @(posedge clk) begin
        cnt_q <= (cnt_q == 9'h12B) ? '0 : cnt_q + 9'h1;
    end
    assign hw_conv_trigger = trig_en && cnt_q < 9'h4;
endmodule

/* File: verif/sar_adc_conversion_control_tb.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_cfg.svh"
module sar_adc_conversion_control_tb;
    import adc_pkg::*;
    logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ten = 0;
    logic [7:0]  adr = '0;
    logic [31:0] dat = '0, dout, r, h;
    logic [9:0]  lvl = '0, dac;
    logic [23:0] ext;
    logic        ack, cmp, trg, irq, pwr, tmp, bg, rh, rl, lp, smp;
    logic        aclk = 0, stp = 0;
    int          miscompares = 0, tests_run = 0, cyc_n = 0;
    // design and far side
    sar_adc_conversion_control i_dut (.clk(clk), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(dout), .wb_ack_o(ack),
        .hw_conv_trigger(trg), .alternate_conv_clock(aclk),
        .local_async_conv_clock(aclk), .stop_mode(stp),
        .comparator_in(cmp), .ext_chan_sel(ext),
        .temp_sensor_channel_sel(tmp), .bandgap_channel_sel(bg),
        .ref_high_sel(rh), .ref_low_sel(rl), .sar_power(pwr),
        .low_power(lp), .sample_switch(smp), .dac_code(dac), .conv_irq(irq));
    analog_far_model i_far (.clk(clk), .trig_en(ten), .level(lvl),
        .dac_code(dac), .comparator_in(cmp), .hw_conv_trigger(trg));
    initial begin
        forever #10 clk = ~clk;
    end
    always #500 aclk = ~aclk; // 1 MHz slow conversion clock
    // verdict and end of run
    task automatic stop_test;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            $display("[FAIL] %0t %s", $time, m);
            miscompares++;
        end
    endtask
    // one classic wishbone cycle, read data kept in r
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wdone(input int lim);
        int n;
        n = 0;
        do begin
            bus(0, `OFS_CTRL1, 0);
            n++;
        end while (r[7] !== 1'b1 && n < lim);
    endtask
    function automatic logic [27:0] exp_sel(input logic [4:0] c);
        exp_sel = '0;
        if (c < 5'd24) exp_sel[c + 4] = 1'b1;
        else if (c == `CHAN_TEMP) exp_sel[3] = 1'b1;
        else if (c == `CHAN_BG) exp_sel[2] = 1'b1;
        else if (c == `CHAN_REFH0 || c == `CHAN_REFH1) exp_sel[1] = 1'b1;
        else if (c == `CHAN_REFL) exp_sel[0] = 1'b1;
    endfunction
    function automatic logic [9:0] exp_res(input logic [9:0] v,
                                           input logic m10);
        exp_res = m10 ? v : {2'b00, v[9:2]};
    endfunction
    // cycle ceiling against hangs
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            miscompares++;
            stop_test;
        end
    end
    // main sequence
    initial begin
        void'($urandom(23));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, `OFS_CTRL1, 0);
        chk(r[4:0] === `CHAN_RST, "chan reset");
        bus(0, 8'h3C, 0);
        chk(r === '0, "unmapped read");
        bus(1, `OFS_CFG, 32'h08); // bus clock, no divide
        for (int c = 0; c < 32; c++) begin
            bus(1, `OFS_CTRL1, c);
            repeat (3) @(posedge clk);
            chk({ext, tmp, bg, rh, rl} === exp_sel(c[4:0]), "select");
            chk(pwr === (c != 31), "power");
        end
        for (int i = 0; i < 6; i++) begin
            lvl <= (i < 2) ? {10{i[0]}} : 10'($urandom_range(1023));
            bus(1, `OFS_CFG, i[0] ? 32'h88 : 32'h00);
            bus(1, `OFS_CTRL1, 32'h40 | (i + 1));
            wdone(60);
            chk(irq === 1'b1, "irq");
            bus(0, `OFS_RES_HI, 0);
            h = r;
            bus(0, `OFS_RES_LO, 0);
            chk({h[1:0], r[7:0]} === exp_res(lvl, i[0]), "result");
            bus(0, `OFS_CTRL1, 0);
            chk(r[7] === 1'b0 && pwr === 1'b0, "idle");
            chk(lp === i[0] && smp === 1'b0, "low power");
        end
        lvl <= 10'h155;
        bus(1, `OFS_CFG, 32'h08);
        bus(1, `OFS_CMP, 32'h156);
        bus(1, `OFS_CTRL2, 32'h30);
        bus(1, `OFS_CTRL1, 32'h03);
        repeat (200) @(posedge clk);
        bus(0, `OFS_CTRL1, 0);
        chk(r[7] === 1'b0, "cmp miss");
        bus(1, `OFS_CTRL2, 32'h20);
        bus(1, `OFS_CTRL1, 32'h03);
        wdone(60);
        chk(r[7] === 1'b1, "cmp hit");
        bus(1, `OFS_CTRL2, 0);
        bus(1, `OFS_CTRL1, 32'h05);
        bus(1, `OFS_CTRL1, 32'h1F);
        repeat (200) @(posedge clk);
        bus(0, `OFS_CTRL1, 0);
        chk(r[7] === 1'b0 && pwr === 1'b0, "off");
        bus(1, `OFS_CTRL2, 32'h40);
        bus(1, `OFS_CTRL1, 32'h02);
        bus(0, `OFS_CTRL2, 0);
        chk(r[7] === 1'b0, "armed idle");
        ten <= 1'b1;
        stp <= 1'b1; // stop with alternate clock unselected
        wdone(200);
        chk(r[7] === 1'b1, "hw start");
        bus(1, `OFS_CTRL2, 0);
        bus(1, `OFS_CFG, 32'h1B); // slow local clock, long
        bus(1, `OFS_CTRL1, 32'h1A);
        wdone(800);
        bus(0, `OFS_RES_LO, 0);
        chk(r[7:0] === lvl[7:0] && tmp === 1'b1, "sensor");
        stop_test;
    end
endmodule

/* File: verilog/adc_cfg.svh */
// register offsets, field positions, reset values and timing counts
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH
`define OFS_CTRL1   8'h00
`define OFS_CTRL2   8'h04
`define OFS_RES_HI  8'h08
`define OFS_RES_LO  8'h0C
`define OFS_CMP     8'h10
`define OFS_CFG     8'h14
`define C1_DONE     7
`define C1_IEN      6
`define C1_CONT     5
`define C2_ACTIVE   7
`define C2_HWT      6
`define C2_CMPEN    5
`define C2_CMPGE    4
`define CF_LP       7
`define CF_DIV_HI   6
`define CF_DIV_LO   5
`define CF_LONG     4
`define CF_MODE10   3
`define CF_CLK_HI   1
`define CF_CLK_LO   0
`define N_EXT       24
`define CHAN_RSV0   5'h18
`define CHAN_RSV1   5'h19
`define CHAN_TEMP   5'h1A
`define CHAN_BG     5'h1B
`define CHAN_REFH0  5'h1C
`define CHAN_REFH1  5'h1D
`define CHAN_REFL   5'h1E
`define CHAN_OFF    5'h1F
`define CHAN_RST    5'h1F
`define SMP_SHORT   5'h04
`define SMP_LONG    5'h18
`define SETTLE_CYC  3'h5
`define MSB_IDX     4'h9
`define MSB_TRIAL   10'h200
`endif

/* File: verilog/adc_pkg.sv */
// types shared by the converter control modules
package adc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_CONV  = 3'b100
    } ctl_state_t;
    typedef enum logic [1:0] {
        SRC_BUS      = 2'h0,
        SRC_BUS_DIV2 = 2'h1,
        SRC_ALT      = 2'h2,
        SRC_ASYNC    = 2'h3
    } clk_src_t;
    typedef enum logic [2:0] {
        SAR_IDLE   = 3'b001,
        SAR_SAMPLE = 3'b010,
        SAR_BIT    = 3'b100
    } sar_state_t;
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        ctl_state_t  state;
        logic [4:0]  chan;
        logic        irq_en;
        logic        cont;
        logic        hw_en;
        logic        cmp_en;
        logic        cmp_ge;
        logic        low_power;
        logic [1:0]  div;
        logic        long_smp;
        logic        mode10;
        clk_src_t    clk_sel;
        logic [9:0]  cmp_val;
        logic [9:0]  result;
        logic        done;
        logic        irq;
        logic [2:0]  trig_s;
        logic        trig_lvl;
        logic        start;
        logic        abort;
        logic [23:0] ext_sel;
        logic        temp_sel;
        logic        bg_sel;
        logic        refh_sel;
        logic        refl_sel;
        logic        sar_power;
    } ctl_st_t;
    typedef struct packed {
        sar_state_t state;
        logic [4:0] cnt;
        logic [2:0] settle;
        logic [3:0] bitidx;
        logic [9:0] code;
        logic [2:0] cmp_s;
        logic       cmp_lvl;
        logic       sample;
        logic       done;
        logic [9:0] result;
    } sar_st_t;
    typedef struct packed {
        logic       half;
        logic [2:0] alt_s;
        logic       alt_lvl;
        logic [2:0] asy_s;
        logic       asy_lvl;
        logic [2:0] div_cnt;
        logic       tick;
    } cgen_st_t;
endpackage

/* File: verilog/conv_clock_gen.sv */
// conversion clock source select and divider, as a tick on clk
`timescale 1ns/1ps
`include "adc_cfg.svh"
module conv_clock_gen
    import adc_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // clock sources and mode
    input  wire logic       alternate_conv_clock,
    input  wire logic       local_async_conv_clock,
    input  wire logic       stop_mode,
    // selection
    input  wire clk_src_t   clk_sel,
    input  wire logic [1:0] clock_divide_select,
    // divided conversion clock tick
    output wire logic       conv_tick
);
    cgen_st_t   q;
    cgen_st_t   d;
    logic       pre;
    logic       alt_rise;
    logic       asy_rise;
    logic [2:0] lim;

    // source edge detect, select and divide
    always_comb begin
        d = q;
        d.half = ~q.half;
        d.alt_s = {q.alt_s[1:0], alternate_conv_clock};
        d.asy_s = {q.asy_s[1:0], local_async_conv_clock};
        if (q.alt_s[1] == q.alt_s[2]) d.alt_lvl = q.alt_s[2];
        if (q.asy_s[1] == q.asy_s[2]) d.asy_lvl = q.asy_s[2];
        alt_rise = (q.alt_s[1] == q.alt_s[2]) & q.alt_s[2] & ~q.alt_lvl;
        asy_rise = (q.asy_s[1] == q.asy_s[2]) & q.asy_s[2] & ~q.asy_lvl;
        unique case (clk_sel) // see RULE6
            SRC_BUS:      pre = 1'b1;
            SRC_BUS_DIV2: pre = q.half;
            SRC_ALT:      pre = alt_rise & ~stop_mode; // see RULE8
            SRC_ASYNC:    pre = asy_rise;
        endcase
        lim = 3'((4'h1 << clock_divide_select) - 4'h1);
        d.tick = 1'b0;
        if (pre) begin
            if (q.div_cnt >= lim) begin
                d.tick = 1'b1;
                d.div_cnt = 3'h0;
            end else begin
                d.div_cnt = q.div_cnt + 3'h1;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) q <= '0;
        else q <= d;
    end

    assign conv_tick = q.tick;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_bus_undivided: assert property ( // see RULE6
        (clk_sel == SRC_BUS && clock_divide_select == 2'h0) |=> conv_tick)
        else $error("bus clock undivided gave no tick");
    chk_alt_stop_off: assert property ( // see RULE8
        (clk_sel == SRC_ALT && stop_mode) |=> !conv_tick)
        else $error("alternate clock ticked in stop");
endmodule

/* File: verilog/sar_adc_conversion_control.sv */
// register file, trigger, sequencing and result handling of the converter
//
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "adc_cfg.svh"
// Overview of operation
// RULE1 - codes 0..23 pick external inputs; 1C and 1D high reference; 1E low
// RULE2 - reserved codes 18 and 19 still convert, result meaningless
// RULE3 - code 1A routes the temperature sensor channel
// RULE4 - code 1B routes the bandgap channel
// RULE5 - bits for absent channels act reserved, selecting nothing
// RULE6 - conversion clock from bus, bus half, local async or alternate
// RULE7 - software keeps the divided conversion clock inside its range
// RULE8 - alternate clock stays usable in wait mode
// RULE9 - software avoids the alternate clock in stop modes
// RULE10 - with hardware trigger on, counter overflow starts a conversion; in single mode only the first overflow after a control write
// RULE11 - hardware trigger works in run, wait and third stop mode
// RULE12 - ten-bit linear successive approximation search per sample
// RULE13 - results right-justified, ten or eight bits as configured
// RULE14 - single or continuous; single returns to idle alone
// RULE15 - completion flag with interrupt request
// RULE16 - optional compare, less-than or greater-or-equal, flags on hit
// RULE17 - sample time and speed versus power are configurable
// RULE18 - conversions continue in wait and third stop mode
// RULE19 - software picks long sample and slow clock for the sensor
// RULE20 - all-ones code powers the converter off, no trailing conversion
// RULE21 - control write aborts and restarts unless the code is all ones; with hardware trigger on, the code arms and waits for an overflow instead
// RULE22 - flag sets per conversion or compare hit; write or read clears
// RULE23 - overflow synchronised, one start each, ignored while converting
module sar_adc_conversion_control
    import adc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output wire logic [31:0] wb_dat_o,
    output wire logic        wb_ack_o,
    // trigger, clocks and processor mode
    input  wire logic        hw_conv_trigger,
    input  wire logic        alternate_conv_clock,
    input  wire logic        local_async_conv_clock,
    input  wire logic        stop_mode,
    // analog front end
    input  wire logic        comparator_in,
    output wire logic [23:0] ext_chan_sel,
    output wire logic        temp_sensor_channel_sel,
    output wire logic        bandgap_channel_sel,
    output wire logic        ref_high_sel,
    output wire logic        ref_low_sel,
    output wire logic        sar_power,
    output wire logic        low_power,
    output wire logic        sample_switch,
    output wire logic [9:0]  dac_code,
    // interrupt request
    output wire logic        conv_irq
);
    ctl_st_t     q;
    ctl_st_t     d;
    logic        req;
    logic        wr;
    logic        rd;
    logic [7:0]  adr;
    logic        trig_rise;
    logic        wr_c1;
    logic        hit;
    logic [9:0]  fmt;
    logic [9:0]  cv;
    logic [23:0] ext_dec;
    logic        conv_tick;
    sar_if       sar ();

    // one decoder per external input, absent codes select nothing
    genvar gi;
    generate
        for (gi = 0; gi < `N_EXT; gi++) begin : g_ext
            assign ext_dec[gi] = (d.chan == 5'(gi)); // see RULE1
        end
    endgenerate

    // bus decode, registers, trigger and sequencing
    always_comb begin
        d = q;
        d.start = 1'b0;
        d.abort = 1'b0;
        adr = {wb_adr_i[7:2], 2'b00};
        req = wb_cyc_i & wb_stb_i;
        wr = req & q.ack & wb_we_i;
        rd = req & q.ack & ~wb_we_i;
        wr_c1 = wr & wb_sel_i[0] & (adr == `OFS_CTRL1);
        d.ack = req & ~q.ack;
        // read data, unmapped reads as zero
        d.rdata = 32'h0000_0000;
        if (req & ~q.ack & ~wb_we_i) begin
            unique case (adr)
                `OFS_CTRL1: begin
                    d.rdata[`C1_DONE] = q.done;
                    d.rdata[`C1_IEN] = q.irq_en;
                    d.rdata[`C1_CONT] = q.cont;
                    d.rdata[4:0] = q.chan;
                end
                `OFS_CTRL2: begin
                    d.rdata[`C2_ACTIVE] = (q.state == ST_CONV);
                    d.rdata[`C2_HWT] = q.hw_en;
                    d.rdata[`C2_CMPEN] = q.cmp_en;
                    d.rdata[`C2_CMPGE] = q.cmp_ge;
                end
                `OFS_RES_HI: d.rdata[1:0] = q.result[9:8];
                `OFS_RES_LO: d.rdata[7:0] = q.result[7:0];
                `OFS_CMP:    d.rdata[9:0] = q.cmp_val;
                `OFS_CFG: begin
                    d.rdata[`CF_LP] = q.low_power;
                    d.rdata[`CF_DIV_HI:`CF_DIV_LO] = q.div;
                    d.rdata[`CF_LONG] = q.long_smp;
                    d.rdata[`CF_MODE10] = q.mode10;
                    d.rdata[`CF_CLK_HI:`CF_CLK_LO] = q.clk_sel;
                end
                default: d.rdata = 32'h0000_0000;
            endcase
        end
        // overflow pin: three stages, change once stages two and three agree
        d.trig_s = {q.trig_s[1:0], hw_conv_trigger};
        if (q.trig_s[1] == q.trig_s[2]) d.trig_lvl = q.trig_s[2];
        trig_rise = (q.trig_s[1] == q.trig_s[2]) & q.trig_s[2]
                    & ~q.trig_lvl; // see RULE23
        // result formatting and compare
        fmt = q.mode10 ? sar.result : {2'b00, sar.result[9:2]}; // see RULE13
        cv = q.mode10 ? q.cmp_val : {2'b00, q.cmp_val[7:0]};
        hit = q.cmp_ge ? (fmt >= cv) : (fmt < cv); // see RULE16
        // register writes
        if (wr & wb_sel_i[0]) begin
            unique case (adr)
                `OFS_CTRL2: begin
                    d.hw_en = wb_dat_i[`C2_HWT];
                    d.cmp_en = wb_dat_i[`C2_CMPEN];
                    d.cmp_ge = wb_dat_i[`C2_CMPGE];
                end
                `OFS_CMP: d.cmp_val[7:0] = wb_dat_i[7:0];
                `OFS_CFG: begin
                    d.low_power = wb_dat_i[`CF_LP]; // see RULE17
                    d.div = wb_dat_i[`CF_DIV_HI:`CF_DIV_LO];
                    d.long_smp = wb_dat_i[`CF_LONG];
                    d.mode10 = wb_dat_i[`CF_MODE10];
                    d.clk_sel = clk_src_t'(wb_dat_i[`CF_CLK_HI:`CF_CLK_LO]);
                end
                default: begin
                end
            endcase
        end
        if (wr & wb_sel_i[1] & (adr == `OFS_CMP))
            d.cmp_val[9:8] = wb_dat_i[9:8];
        // clears first so that a completing conversion wins
        if (wr_c1 | (rd & (adr == `OFS_RES_LO)))
            d.done = 1'b0; // see RULE22
        // sequencing; no mode input gates any of it
        unique case (q.state) // see RULE11 RULE18
            ST_IDLE: begin
            end
            ST_ARMED: if (trig_rise) begin // see RULE10
                d.start = 1'b1;
                d.state = ST_CONV;
            end
            ST_CONV: if (sar.done) begin // see RULE23
                if (!q.cont) d.state = ST_IDLE; // see RULE14
                else if (q.hw_en) d.state = ST_ARMED;
                else d.start = 1'b1;
            end
        endcase
        // completion, including reserved-channel results
        if (sar.done && q.state == ST_CONV) begin // see RULE2
            d.result = fmt;
            if (!q.cmp_en || hit) d.done = 1'b1; // see RULE22 RULE15
        end
        // control write aborts, then restarts, arms on hardware trigger, or goes idle on the all-ones code
        if (wr_c1) begin
            d.irq_en = wb_dat_i[`C1_IEN];
            d.cont = wb_dat_i[`C1_CONT];
            d.chan = wb_dat_i[4:0];
            d.abort = 1'b1; // see RULE21
            d.start = 1'b0;
            if (wb_dat_i[4:0] == `CHAN_OFF) begin
                d.state = ST_IDLE; // see RULE20
            end else if (d.hw_en) begin
                d.state = ST_ARMED;
            end else begin
                d.start = 1'b1;
                d.state = ST_CONV;
            end
        end
        // analog routing, reserved and absent codes route nothing
        d.ext_sel = ext_dec; // see RULE5
        d.temp_sel = (d.chan == `CHAN_TEMP); // see RULE3
        d.bg_sel = (d.chan == `CHAN_BG); // see RULE4
        d.refh_sel = (d.chan == `CHAN_REFH0) | (d.chan == `CHAN_REFH1);
        d.refl_sel = (d.chan == `CHAN_REFL); // see RULE1
        d.sar_power = (d.state == ST_CONV); // see RULE20
        d.irq = d.done & d.irq_en; // see RULE15
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.state <= ST_IDLE;
            q.chan <= `CHAN_RST;
            q.clk_sel <= SRC_BUS;
        end else begin
            q <= d;
        end
    end

    // engine handshake
    assign sar.start = q.start;
    assign sar.abort = q.abort;
    assign sar.long_sample = q.long_smp;

    conv_clock_gen u_clk (
        .clk                    (clk),
        .rst_n                  (rst_n),
        .alternate_conv_clock   (alternate_conv_clock),
        .local_async_conv_clock (local_async_conv_clock),
        .stop_mode              (stop_mode),
        .clk_sel                (q.clk_sel),
        .clock_divide_select    (q.div),
        .conv_tick              (conv_tick)
    );

    sar_engine u_eng (
        .clk           (clk),
        .rst_n         (rst_n),
        .sar           (sar.eng),
        .conv_tick     (conv_tick),
        .comparator_in (comparator_in),
        .dac_code      (dac_code),
        .sample_switch (sample_switch)
    );

    // outputs
    assign wb_dat_o = q.rdata;
    assign wb_ack_o = q.ack;
    assign ext_chan_sel = q.ext_sel;
    assign temp_sensor_channel_sel = q.temp_sel;
    assign bandgap_channel_sel = q.bg_sel;
    assign ref_high_sel = q.refh_sel;
    assign ref_low_sel = q.refl_sel;
    assign sar_power = q.sar_power;
    assign low_power = q.low_power;
    assign conv_irq = q.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_sw_write(logic [4:0] c);
        wr_c1 && !q.hw_en && wb_dat_i[4:0] == c;
    endsequence
    sequence s_running;
        q.state == ST_CONV && q.start && q.abort;
    endsequence

    chk_ext_decode: assert property ( // see RULE1
        q.chan < 5'h18 |-> q.ext_sel[q.chan] && $onehot(q.ext_sel))
        else $error("external channel decode wrong");
    chk_ref_high: assert property ( // see RULE1
        (q.chan == `CHAN_REFH0 || q.chan == `CHAN_REFH1)
        |-> q.refh_sel && !q.refl_sel && q.ext_sel == 24'h0)
        else $error("high reference not routed");
    chk_reserved_conv: assert property ( // see RULE2
        s_sw_write(`CHAN_RSV1) |=> s_running ##0 q.ext_sel == 24'h0)
        else $error("reserved channel did not convert");
    chk_temp_route: assert property ( // see RULE3
        q.chan == `CHAN_TEMP |-> q.temp_sel && !q.bg_sel)
        else $error("temperature sensor not routed");
    chk_bandgap_route: assert property ( // see RULE4
        q.chan == `CHAN_BG |-> q.bg_sel && !q.temp_sel)
        else $error("bandgap not routed");
    chk_hw_start: assert property ( // see RULE10
        (q.state == ST_ARMED && trig_rise && !wr_c1)
        |=> q.start && q.state == ST_CONV)
        else $error("overflow did not start conversion");
    chk_busy_ignore: assert property ( // see RULE23
        (q.state == ST_CONV && trig_rise && !sar.done && !wr_c1)
        |=> !q.start && q.state == ST_CONV)
        else $error("overflow restarted a running conversion");
    chk_off_stays: assert property ( // see RULE20
        (wr_c1 && wb_dat_i[4:0] == `CHAN_OFF)
        |=> (q.state == ST_IDLE && !q.start && !q.sar_power)[*2])
        else $error("all-ones code still converted");
    chk_flag_set: assert property ( // see RULE22
        (sar.done && q.state == ST_CONV && !q.cmp_en) |=> q.done)
        else $error("flag missed a completed conversion");
    chk_flag_clear: assert property ( // see RULE22
        (wr_c1 && !sar.done) |=> !q.done ##1 !q.irq)
        else $error("control write did not clear flag");
    chk_single_idle: assert property ( // see RULE14
        (sar.done && q.state == ST_CONV && !q.cont && !wr_c1)
        |=> q.state == ST_IDLE ##1 !q.sar_power)
        else $error("single conversion did not return to idle");
    chk_eight_bit: assert property ( // see RULE13
        (sar.done && q.state == ST_CONV && !q.mode10 && !wr_c1)
        |=> q.result[9:8] == 2'b00)
        else $error("eight-bit result not right-justified");
    chk_ack_pulse: assert property (
        (req && !q.ack) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle");
endmodule

/* File: verilog/sar_engine.sv */
// successive approximation search over a 10-bit trial code
`timescale 1ns/1ps
`include "adc_cfg.svh"
module sar_engine
    import adc_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control handshake
    sar_if.eng              sar,
    // conversion clock tick and analog side
    input  wire logic       conv_tick,
    input  wire logic       comparator_in,
    output wire logic [9:0] dac_code,
    output wire logic       sample_switch
);
    sar_st_t    q;
    sar_st_t    d;
    logic [4:0] smp_lim;

    // sample phase then one bit per settled tick
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.cmp_s = {q.cmp_s[1:0], comparator_in};
        if (q.cmp_s[1] == q.cmp_s[2]) d.cmp_lvl = q.cmp_s[2];
        smp_lim = sar.long_sample ? `SMP_LONG : `SMP_SHORT; // see RULE17
        if (sar.start) begin
            d.state = SAR_SAMPLE;
            d.cnt = 5'h00;
            d.sample = 1'b1;
            d.code = 10'h000;
        end else if (sar.abort) begin
            d.state = SAR_IDLE;
            d.sample = 1'b0;
            d.code = 10'h000;
        end else begin
            unique case (q.state)
                SAR_IDLE: begin
                end
                SAR_SAMPLE: if (conv_tick) begin
                    if (q.cnt >= smp_lim - 5'h01) begin
                        d.sample = 1'b0;
                        d.state = SAR_BIT;
                        d.bitidx = `MSB_IDX;
                        d.code = `MSB_TRIAL;
                        d.settle = 3'h0;
                    end else begin
                        d.cnt = q.cnt + 5'h01;
                    end
                end
                SAR_BIT: begin
                    // wait out the comparator synchroniser delay
                    if (q.settle != `SETTLE_CYC)
                        d.settle = q.settle + 3'h1;
                    if (conv_tick && q.settle == `SETTLE_CYC) begin
                        d.code[q.bitidx] = q.cmp_lvl; // see RULE12
                        d.settle = 3'h0;
                        if (q.bitidx == 4'h0) begin
                            d.done = 1'b1;
                            d.result = d.code;
                            d.state = SAR_IDLE;
                        end else begin
                            d.bitidx = q.bitidx - 4'h1;
                            d.code[q.bitidx - 4'h1] = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.state <= SAR_IDLE; // all-zero is no legal state
        end else begin
            q <= d;
        end
    end

    assign sar.busy = (q.state != SAR_IDLE);
    assign sar.done = q.done;
    assign sar.result = q.result;
    assign dac_code = q.code;
    assign sample_switch = q.sample;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_done_last_bit: assert property ( // see RULE12
        q.done |-> $past(q.bitidx) == 4'h0 && $past(q.state) == SAR_BIT)
        else $error("done without finishing the last bit");
    chk_start_samples: assert property ( // see RULE17
        sar.start |=> q.sample && q.state == SAR_SAMPLE && q.cnt == 5'h00)
        else $error("start did not open sampling");
endmodule

/* File: verilog/sar_if.sv */
// handshake between conversion control and the approximation engine
`timescale 1ns/1ps
interface sar_if;
    logic       start;
    logic       abort;
    logic       long_sample;
    logic       busy;
    logic       done;
    logic [9:0] result;
    modport ctl (output start, abort, long_sample,
                 input  busy, done, result);
    modport eng (input  start, abort, long_sample,
                 output busy, done, result);
endinterface
